// ===== design/psom_pkg.sv
// psom_pkg: constants, types and shared decode for the scan operand memory
package psom_pkg;
	localparam int CLK_HZ = 100000000;
	localparam int TICK_FAST_MS = 10;
	localparam int TICK_SLOW_MS = 100;
	localparam int TICK_FAST_CYC = CLK_HZ / 1000 * TICK_FAST_MS;
	localparam int SLOW_PER_FAST = TICK_SLOW_MS / TICK_FAST_MS;
	localparam int PHYS_POINTS = 8;
	localparam int XY_POINTS = 128;
	localparam int M_POINTS = 128;
	localparam int T_NUM = 64;
	localparam int T_SLOW_NUM = 48;
	localparam int T_ACC_SLOW_LO = 46;
	localparam int T_ACC_FAST_LO = 62;
	localparam int C_NUM = 66;
	localparam int C_GEN_NUM = 64;
	localparam int HW_CNT = 2;
	localparam int D_NUM = 392;
	localparam int IDX_NUM = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_OPADDR = 8'h08;
	localparam logic [7:0] REG_OPWDATA = 8'h0C;
	localparam logic [7:0] REG_OPCMD = 8'h10;
	localparam logic [7:0] REG_OPRDATA = 8'h14;
	localparam logic [7:0] REG_OUTMEM = 8'h18;
	localparam int CTRL_START = 0;
	localparam int CTRL_END = 1;
	localparam int STAT_ERR = 4;
	localparam int OPA_TYPE_LSB = 16;
	localparam int OPA_WIDE = 20;
	localparam int OPC_INPUT = 8;
	localparam logic [31:0] OPADDR_RST = 32'h0000_0000;
	localparam logic [31:0] OPWDATA_RST = 32'h0000_0000;
	typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_EXEC, PH_COMMIT} psom_phase_t;
	typedef enum logic [3:0] {OT_X, OT_Y, OT_M, OT_T, OT_C, OT_TV, OT_CV, OT_D, OT_A, OT_B, OT_H} psom_op_t;
	typedef enum logic [3:0] {CMD_NOP, CMD_WRITE, CMD_READ, CMD_DELAY, CMD_TALLY, CMD_CLEAR} psom_cmd_t;

	// octal digits one per nibble; bit 7 of the result flags a bad digit or index above 177
	function automatic logic [7:0] octDecode(input logic [11:0] n);
		return {n[3] | n[7] | n[11] | (n[10:8] > 3'h1), n[8], n[6:4], n[2:0]};
	endfunction

	function automatic logic isAccum(input int i);
		return (i >= T_ACC_SLOW_LO && i < T_SLOW_NUM) || (i >= T_ACC_FAST_LO && i < T_NUM);
	endfunction

	function automatic logic inRange(input psom_op_t t, input logic [11:0] raw, input logic wide);
		logic [7:0] o;
		o = octDecode(raw);
		case (t)
			OT_X, OT_Y: return !o[7];
			OT_M: return raw < 12'(M_POINTS);
			OT_T, OT_TV: return raw < 12'(T_NUM);
			OT_C, OT_CV: return raw < 12'(C_NUM);
			OT_D: return (raw + 12'(wide)) < 12'(D_NUM);
			OT_A, OT_B: return raw < 12'(IDX_NUM);
			OT_H: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// ===== design/psom_sync.sv
// psom_sync: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module psom_sync #(
	parameter int WIDTH = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule // psom_sync

// ===== design/psom_tick.sv
// psom_tick: fast and slow time-base enables from the system clock
`timescale 1ns/10ps
module psom_tick #(
	parameter int FAST_CYC = psom_pkg::TICK_FAST_CYC,
	parameter int SLOW_DIV = psom_pkg::SLOW_PER_FAST
) (
	input wire logic clk,
	input wire logic rst,
	output logic tickFast,
	output logic tickSlow
);
	import psom_pkg::*;
	logic [31:0] div_r;
	logic [7:0] slow_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r <= '0;
			tickFast <= 1'b0;
		end else begin
			tickFast <= (div_r == 32'(FAST_CYC - 1));
			div_r <= (div_r == 32'(FAST_CYC - 1)) ? '0 : div_r + 32'h0000_0001;
		end
	end

	// slow tick coincides with every SLOW_DIV-th fast tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slow_r <= '0;
			tickSlow <= 1'b0;
		end else begin
			tickSlow <= 1'b0;
			if (div_r == 32'(FAST_CYC - 1)) begin
				tickSlow <= (slow_r == 8'(SLOW_DIV - 1));
				slow_r <= (slow_r == 8'(SLOW_DIV - 1)) ? '0 : slow_r + 8'h01;
			end
		end
	end
endmodule // psom_tick

// ===== design/psom_core.sv
// psom_core: scan-cycle operand memory and input/output image with an APB register port
// What this block does
// - I/O operand indices are octal, no 8/9
// - sample all inputs at scan start, hold
// - pulses shorter than a scan are missed
// - each scan restarts at line 0, stores operands
// - outputs change only after end instruction
// - last coil write in a scan wins
// - 128 input points, 0-7 physical, rest virtual
// - 128 internal relays, 100-110 special purpose
// - 64 timers, 100/10 ms ticks, four accumulative
// - one current value per timer, 64 total
// - counters 64 and 65 count hardware pulses
// - 32-bit current value for 66 counters
// - data registers 320-351 retained, 352-391 special
// - eight index pairs, low and high halves
// - hex constants span 16 or 32 bits
// - timer contact sets when count reaches set value
// - counter counts rising edges, contact at setpoint
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module psom_core #(
	parameter int TICK_FAST_CYC = psom_pkg::TICK_FAST_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [psom_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [psom_pkg::PHYS_POINTS-1:0] inPin,
	input wire logic [psom_pkg::HW_CNT-1:0] cntPin,
	output logic [psom_pkg::PHYS_POINTS-1:0] physOut,
	output logic [psom_pkg::XY_POINTS-1:psom_pkg::PHYS_POINTS] virtOut
);
	import psom_pkg::*;

	logic [PHYS_POINTS+HW_CNT-1:0] pinSync;
	logic [HW_CNT-1:0] hwPrev_r;
	logic [HW_CNT-1:0] hwEdge;
	logic tickFast;
	logic tickSlow;
	psom_phase_t phase_r;
	logic [15:0] lineCnt_r;
	logic err_r;
	logic [31:0] opAddr_r;
	logic [31:0] opWdata_r;
	logic [31:0] opRdata_r;
	logic [XY_POINTS-1:0] xImg_r;
	logic [XY_POINTS-1:PHYS_POINTS] xPend_r;
	logic [XY_POINTS-1:0] yImg_r;
	logic [XY_POINTS-1:0] outMem_r;
	logic [M_POINTS-1:0] mRel_r;
	logic [15:0] tCur_r [T_NUM];
	logic [15:0] tSet_r [T_NUM];
	logic [T_NUM-1:0] tRun_r;
	logic [T_NUM-1:0] tArm_r;
	logic [T_NUM-1:0] tCont_r;
	logic [31:0] cCur_r [C_NUM];
	logic [31:0] cSet_r [C_NUM];
	logic [C_NUM-1:0] cArm_r;
	logic [C_NUM-1:0] cCont_r;
	logic [C_GEN_NUM-1:0] cPrev_r;
	logic [15:0] dMem [D_NUM];
	logic [15:0] aLow_r [IDX_NUM];
	logic [15:0] bHigh_r [IDX_NUM];
	logic wrXfer;
	logic access;
	logic mapped;
	logic opGo;
	psom_cmd_t cmd;
	psom_op_t opType;
	logic opWide;
	logic [11:0] opRaw;
	logic [6:0] opIdx;
	logic [7:0] opOct;
	logic [8:0] opDIdx;
	logic opBad;
	logic cmdIn;
	logic [31:0] opValue;

	psom_sync #(
		.WIDTH(PHYS_POINTS + HW_CNT)
	) uSync (
		.clk(clk),
		.rst(rst),
		.din({cntPin, inPin}),
		.dout(pinSync)
	);

	psom_tick #(
		.FAST_CYC(TICK_FAST_CYC),
		.SLOW_DIV(SLOW_PER_FAST)
	) uTick (
		.clk(clk),
		.rst(rst),
		.tickFast(tickFast),
		.tickSlow(tickSlow)
	);

	// zero-wait slave: read data is captured in the setup cycle
	assign pready = 1'b1;
	assign access = psel && penable;
	assign wrXfer = access && pwrite && mapped;
	assign pslverr = access && !mapped;

	always_comb begin
		case (paddr)
			REG_CTRL, REG_STATUS, REG_OPADDR, REG_OPWDATA, REG_OPCMD, REG_OPRDATA, REG_OUTMEM: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// operand decode shared by every command
	assign opType = psom_op_t'(opAddr_r[OPA_TYPE_LSB +: 4]);
	assign opWide = opAddr_r[OPA_WIDE];
	assign opRaw = opAddr_r[11:0];
	// a function result cannot be part-selected directly, so it lands on a net first
	assign opOct = octDecode(opRaw);
	assign opIdx = (opType == OT_X || opType == OT_Y) ? opOct[6:0] : opRaw[6:0];
	assign opDIdx = opRaw[8:0];
	assign cmd = psom_cmd_t'(pwdata[3:0]);
	assign cmdIn = pwdata[OPC_INPUT];
	assign opGo = wrXfer && paddr == REG_OPCMD && cmd != CMD_NOP && phase_r == PH_EXEC;

	// commands outside range or on read-only operands are refused
	always_comb begin
		opBad = !inRange(opType, opRaw, opWide);
		case (cmd)
			CMD_WRITE: opBad = opBad || opType == OT_T || opType == OT_C || opType == OT_H
				|| (opType == OT_X && opIdx < 7'(PHYS_POINTS));
			CMD_DELAY: opBad = opBad || opType != OT_T;
			CMD_TALLY: opBad = opBad || opType != OT_C;
			CMD_CLEAR: opBad = opBad || (opType != OT_T && opType != OT_C);
			default: opBad = opBad;
		endcase
	end

	// scan sequence: idle, sample inputs, execute, commit outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_r <= PH_IDLE;
		end else begin
			case (phase_r)
				PH_IDLE: begin
					if (wrXfer && paddr == REG_CTRL && pwdata[CTRL_START]) begin
						phase_r <= PH_SAMPLE;
					end
				end
				PH_SAMPLE: phase_r <= PH_EXEC;
				PH_EXEC: begin
					if (wrXfer && paddr == REG_CTRL && pwdata[CTRL_END]) begin
						phase_r <= PH_COMMIT;
					end
				end
				PH_COMMIT: phase_r <= PH_IDLE;
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	// program line counter restarts at zero for every scan
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lineCnt_r <= '0;
		end else if (phase_r == PH_SAMPLE) begin
			lineCnt_r <= '0;
		end else if (opGo) begin
			lineCnt_r <= lineCnt_r + 16'h0001;
		end
	end

	// sticky error: a new fault in the clearing cycle keeps the flag set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_r <= 1'b0;
		end else if (opGo && opBad) begin
			err_r <= 1'b1;
		end else if (wrXfer && paddr == REG_STATUS && pwdata[STAT_ERR]) begin
			err_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opAddr_r <= OPADDR_RST;
			opWdata_r <= OPWDATA_RST;
		end else begin
			if (wrXfer && paddr == REG_OPADDR) begin
				opAddr_r <= pwdata;
			end
			if (wrXfer && paddr == REG_OPWDATA) begin
				opWdata_r <= pwdata;
			end
		end
	end

	// input image is only refreshed in the sample phase, so short pulses are not seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xImg_r <= '0;
			xPend_r <= '0;
		end else begin
			if (phase_r == PH_SAMPLE) begin
				xImg_r <= {xPend_r, pinSync[PHYS_POINTS-1:0]};
			end
			if (opGo && !opBad && cmd == CMD_WRITE && opType == OT_X) begin
				xPend_r[opIdx] <= opWdata_r[0];
			end
		end
	end

	// output image may be rewritten freely; only the commit moves it to the pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			yImg_r <= '0;
			outMem_r <= '0;
		end else begin
			if (opGo && !opBad && cmd == CMD_WRITE && opType == OT_Y) begin
				yImg_r[opIdx] <= opWdata_r[0];
			end
			if (phase_r == PH_COMMIT) begin
				outMem_r <= yImg_r;
			end
		end
	end

	assign physOut = outMem_r[PHYS_POINTS-1:0];
	assign virtOut = outMem_r[XY_POINTS-1:PHYS_POINTS];

	// special relays 100-110 are stored like the rest; their side effects live elsewhere
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mRel_r <= '0;
		end else if (opGo && !opBad && cmd == CMD_WRITE && opType == OT_M) begin
			mRel_r[opIdx] <= opWdata_r[0];
		end
	end

	// timers keep running between scans on their own tick
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < T_NUM; i++) begin
				tCur_r[i] <= '0;
				tSet_r[i] <= '0;
			end
			tRun_r <= '0;
			tArm_r <= '0;
			tCont_r <= '0;
		end else begin
			for (int i = 0; i < T_NUM; i++) begin
				if (tRun_r[i] && ((i < T_SLOW_NUM) ? tickSlow : tickFast) && tCur_r[i] < tSet_r[i]) begin
					tCur_r[i] <= tCur_r[i] + 16'h0001;
				end
				tCont_r[i] <= tArm_r[i] && tCur_r[i] >= tSet_r[i];
			end
			if (opGo && !opBad && opType == OT_TV && cmd == CMD_WRITE) begin
				tCur_r[opIdx[5:0]] <= opWdata_r[15:0];
			end
			if (opGo && !opBad && cmd == CMD_DELAY) begin
				if (cmdIn) begin
					tRun_r[opIdx[5:0]] <= 1'b1;
					tArm_r[opIdx[5:0]] <= 1'b1;
					tSet_r[opIdx[5:0]] <= opWdata_r[15:0];
				end else begin
					tRun_r[opIdx[5:0]] <= 1'b0;
					if (!isAccum(int'(opIdx[5:0]))) begin
						tCur_r[opIdx[5:0]] <= '0;
						tArm_r[opIdx[5:0]] <= 1'b0;
					end
				end
			end
			if (opGo && !opBad && cmd == CMD_CLEAR && opType == OT_T) begin
				tCur_r[opIdx[5:0]] <= '0;
				tRun_r[opIdx[5:0]] <= 1'b0;
				tArm_r[opIdx[5:0]] <= 1'b0;
			end
		end
	end

	// hardware counter pins: edge taken after the synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hwPrev_r <= '0;
		end else begin
			hwPrev_r <= pinSync[PHYS_POINTS +: HW_CNT];
		end
	end

	assign hwEdge = pinSync[PHYS_POINTS +: HW_CNT] & ~hwPrev_r;

	// general counters stop at their setpoint; hardware counters do not
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < C_NUM; i++) begin
				cCur_r[i] <= '0;
				cSet_r[i] <= '0;
			end
			cArm_r <= '0;
			cCont_r <= '0;
			cPrev_r <= '0;
		end else begin
			for (int j = 0; j < HW_CNT; j++) begin
				if (hwEdge[j]) begin
					cCur_r[C_GEN_NUM + j] <= cCur_r[C_GEN_NUM + j] + 32'h0000_0001;
				end
			end
			for (int i = 0; i < C_NUM; i++) begin
				cCont_r[i] <= cArm_r[i] && cCur_r[i] == cSet_r[i];
			end
			if (opGo && !opBad && opType == OT_CV && cmd == CMD_WRITE) begin
				cCur_r[opIdx] <= opWdata_r;
			end
			if (opGo && !opBad && cmd == CMD_TALLY) begin
				cSet_r[opIdx] <= opWdata_r;
				cArm_r[opIdx] <= 1'b1;
				if (opIdx < 7'(C_GEN_NUM)) begin
					cPrev_r[opIdx[5:0]] <= cmdIn;
					if (cmdIn && !cPrev_r[opIdx[5:0]] && cCur_r[opIdx] != opWdata_r) begin
						cCur_r[opIdx] <= cCur_r[opIdx] + 32'h0000_0001;
					end
				end
			end
			if (opGo && !opBad && cmd == CMD_CLEAR && opType == OT_C) begin
				cCur_r[opIdx] <= '0;
				cArm_r[opIdx] <= 1'b0;
				if (opIdx < 7'(C_GEN_NUM)) begin
					cPrev_r[opIdx[5:0]] <= 1'b0;
				end
			end
		end
	end

	// data memory has no reset so the retained range keeps its contents
	always_ff @(posedge clk) begin
		if (opGo && !opBad && cmd == CMD_WRITE && opType == OT_D) begin
			dMem[opDIdx] <= opWdata_r[15:0];
			if (opWide) begin
				dMem[opDIdx + 9'h001] <= opWdata_r[31:16];
			end
		end
	end

	// index pairs: low half and high half written separately
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < IDX_NUM; i++) begin
				aLow_r[i] <= '0;
				bHigh_r[i] <= '0;
			end
		end else if (opGo && !opBad && cmd == CMD_WRITE) begin
			if (opType == OT_A) begin
				aLow_r[opIdx[2:0]] <= opWdata_r[15:0];
			end
			if (opType == OT_B) begin
				bHigh_r[opIdx[2:0]] <= opWdata_r[15:0];
			end
		end
	end

	// operand value for the read command
	always_comb begin
		case (opType)
			OT_X: opValue = {31'h0, xImg_r[opIdx]};
			OT_Y: opValue = {31'h0, yImg_r[opIdx]};
			OT_M: opValue = {31'h0, mRel_r[opIdx]};
			OT_T: opValue = {31'h0, tCont_r[opIdx[5:0]]};
			OT_C: opValue = {31'h0, cCont_r[opIdx]};
			OT_TV: opValue = {16'h0, tCur_r[opIdx[5:0]]};
			OT_CV: opValue = cCur_r[opIdx];
			OT_D: opValue = opWide ? {dMem[opDIdx + 9'h001], dMem[opDIdx]} : {16'h0, dMem[opDIdx]};
			OT_A: opValue = {16'h0, aLow_r[opIdx[2:0]]};
			OT_B: opValue = {16'h0, bHigh_r[opIdx[2:0]]};
			OT_H: opValue = opWide ? opWdata_r : {16'h0, opWdata_r[15:0]};
			default: opValue = 32'h0000_0000;
		endcase
	end

	// a refused read leaves the previous result in place
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opRdata_r <= '0;
		end else if (opGo && !opBad && cmd == CMD_READ) begin
			opRdata_r <= opValue;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				REG_STATUS: prdata <= {lineCnt_r, 11'h000, err_r, 2'h0, phase_r};
				REG_OPADDR: prdata <= opAddr_r;
				REG_OPWDATA: prdata <= opWdata_r;
				REG_OPRDATA: prdata <= opRdata_r;
				REG_OUTMEM: prdata <= {24'h00_0000, outMem_r[PHYS_POINTS-1:0]};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // psom_core

// ===== verification/psom_properties.sv
// port checker for the scan operand memory
`timescale 1ns/10ps
module psom_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [psom_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [psom_pkg::PHYS_POINTS-1:0] physOut,
	input wire logic [psom_pkg::XY_POINTS-1:psom_pkg::PHYS_POINTS] virtOut
);
	import psom_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire acc = psel && penable;
	wire bad = (paddr > REG_OUTMEM) || (paddr[1:0] != 2'h0);
	// an end request outside a scan is ignored, so only one direction is checked
	wire endWr = acc && pwrite && (paddr == REG_CTRL) && pwdata[CTRL_END];
	phys_out_hold_a: assert property ($changed(physOut) |-> $past(endWr, 2) || $past(endWr, 3))
		else $error("physical outputs moved without end");
	virt_out_hold_a: assert property ($changed(virtOut) |-> $past(endWr, 2) || $past(endWr, 3))
		else $error("virtual outputs moved without end");
	err_resp_map_a: assert property (acc && bad |-> pslverr)
		else $error("no error on unmapped access");
	err_resp_only_a: assert property (pslverr |-> acc && bad)
		else $error("stray error response");
	setup_no_err_a: assert property (psel && !penable |-> !pslverr)
		else $error("error response in setup cycle");
	bad_read_zero_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	ctrl_read_zero_a: assert property (acc && !pwrite && paddr == REG_CTRL |-> prdata == 32'h0)
		else $error("control read not zero");
	zero_wait_a: assert property (psel && !penable |=> pready)
		else $error("access phase not ready");
	rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved outside read setup");
endmodule // psom_properties

bind psom_core psom_properties u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .physOut(physOut),
	.virtOut(virtOut));

// ===== verification/psom_terminals.sv
// terminal model: drives input and pulse pins
`timescale 1ns/10ps
module psom_terminals (
	input wire logic clk,
	output logic [psom_pkg::PHYS_POINTS-1:0] inPin,
	output logic [psom_pkg::HW_CNT-1:0] cntPin
);
	initial begin
		inPin = 8'h00;
		cntPin = 2'h0;
	end
	task automatic setIn(input logic [7:0] v);
		@(posedge clk);
		inPin <= v;
	endtask
	// pulses held three cycles so the two-flop synchroniser cannot miss them
	task automatic pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			cntPin[k] <= 1'b1;
			repeat (3) @(posedge clk);
			cntPin[k] <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule // psom_terminals

// ===== verification/tb_plc_scan_operand_memory.sv
// self-checking bench for the scan operand memory
`timescale 1ns/10ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin numErrors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_plc_scan_operand_memory;
	import psom_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic [7:0] inPin, physOut;
	logic [1:0] cntPin;
	logic [127:8] virtOut;
	logic [31:0] seed = 32'h3C42F30A;
	logic [63:0] expQ[$];
	int numErrors = 0, checksDone = 0;
	// bit 31 marks operands that must raise the error flag
	localparam logic [31:0] TBL [14] = '{32'h0002_007F, 32'h8002_0080, 32'h0005_003F, 32'h8005_0040,
		32'h0006_0041, 32'h8006_0042, 32'h0007_0187, 32'h8017_0187, 32'h0009_0007, 32'h8008_0008,
		32'h0000_0177, 32'h8000_0178, 32'h8000_0018, 32'h8001_0019};
	always #5 clk = ~clk;
	psom_core #(.TICK_FAST_CYC(10)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .inPin(inPin),
		.cntPin(cntPin), .physOut(physOut), .virtOut(virtOut));
	psom_terminals u_term (.clk(clk), .inPin(inPin), .cntPin(cntPin));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic results();
		// a noted read that never got its answer counts as a mismatch
		if (expQ.size() != 0) begin
			numErrors++;
		end
		$display("checks %0d errors %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			$display("[ERR] %0t bus timeout", $time);
			numErrors++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		expQ.push_back({m, e});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic op(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] c, input logic in);
		wr(REG_OPADDR, ad);
		wr(REG_OPWDATA, d);
		wr(REG_OPCMD, {23'h0, in, 4'h0, c});
	endtask
	task automatic rdOp(input logic [31:0] ad, input logic [31:0] m, input logic [31:0] e);
		op(ad, 32'h0, CMD_READ, 1'b0);
		rd(REG_OPRDATA, m, e);
	endtask
	// read results are judged where they appear, against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
			`CHK(prdata & expQ[0][63:32], expQ[0][31:0])
			void'(expQ.pop_front());
		end
	end
	initial begin
		logic [31:0] r;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(physOut, 8'h00)
		`CHK(virtOut, 120'h0)
		rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0);
		rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
		wr(8'h41, 32'h1);
		u_term.setIn(8'hA5);
		repeat (4) @(posedge clk);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'hFFFF_0003, 32'h2);
		u_term.setIn(8'h5A);
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) rdOp({20'h0, 12'(i)}, 32'h1, 32'(8'hA5 >> i) & 32'h1);
		op(32'h0001_0005, 32'h1, CMD_WRITE, 1'b0);
		op(32'h0001_0005, 32'h0, CMD_WRITE, 1'b0);
		op(32'h0001_0005, 32'h1, CMD_WRITE, 1'b0);
		op(32'h0001_0177, 32'h1, CMD_WRITE, 1'b0);
		op(32'h0001_0010, 32'h1, CMD_WRITE, 1'b0);
		rd(REG_STATUS, 32'hFFFF_0003, 32'h000D_0002);
		`CHK(physOut, 8'h00)
		wr(REG_CTRL, 32'h2);
		repeat (3) @(posedge clk);
		`CHK(physOut, 8'h20)
		`CHK({virtOut[127], virtOut[8]}, 2'h3)
		rd(REG_OUTMEM, 32'hFF, 32'h20);
		wr(REG_CTRL, 32'h1);
		rd(REG_STATUS, 32'hFFFF_0003, 32'h2);
		u_term.setIn(8'hFF);
		repeat (4) @(posedge clk);
		u_term.setIn(8'h5A);
		repeat (4) @(posedge clk);
		wr(REG_CTRL, 32'h2);
		wr(REG_CTRL, 32'h1);
		rdOp(32'h0, 32'h1, 32'h0);
		foreach (TBL[i]) begin
			op({1'b0, TBL[i][30:0]}, 32'h0, CMD_READ, 1'b0);
			rd(REG_STATUS, 32'h10, {27'h0, TBL[i][31], 4'h0});
			wr(REG_STATUS, 32'h10);
		end
		r = xs();
		op(32'h0007_0187, r, CMD_WRITE, 1'b0);
		op(32'h0017_0187, ~r, CMD_WRITE, 1'b0);
		rdOp(32'h0007_0187, 32'hFFFF, r & 32'hFFFF);
		wr(REG_STATUS, 32'h10);
		r = xs();
		op(32'h0017_0140, r, CMD_WRITE, 1'b0);
		rdOp(32'h0007_0141, 32'hFFFF, r >> 16);
		r = xs();
		op(32'h0006_0001, r, CMD_WRITE, 1'b0);
		rdOp(32'h0006_0001, 32'hFFFF_FFFF, r);
		op(32'h0008_0003, r, CMD_WRITE, 1'b0);
		rdOp(32'h0008_0003, 32'hFFFF, r & 32'hFFFF);
		op(32'h0004_0000, 32'h0, CMD_CLEAR, 1'b0);
		rdOp(32'h0004_0000, 32'h1, 32'h0);
		for (int i = 0; i < 6; i++) op(32'h0004_0000, 32'h2, CMD_TALLY, 1'(i % 2));
		rdOp(32'h0006_0000, 32'hFFFF_FFFF, 32'h2);
		rdOp(32'h0004_0000, 32'h1, 32'h1);
		u_term.pulse(0, 3);
		repeat (4) @(posedge clk);
		rdOp(32'h0006_0040, 32'hFFFF_FFFF, 32'h3);
		rdOp(32'h0006_0041, 32'hFFFF_FFFF, 32'h0);
		// setpoint of three slow ticks: the early look spans fewer than 200 cycles, so at most two ticks
		op(32'h0003_0000, 32'h3, CMD_DELAY, 1'b1);
		op(32'h0003_0030, 32'h3, CMD_DELAY, 1'b1);
		rdOp(32'h0003_0030, 32'h1, 32'h0);
		repeat (60) @(posedge clk);
		rdOp(32'h0003_0030, 32'h1, 32'h1);
		rdOp(32'h0005_0030, 32'hFFFF_FFFF, 32'h3);
		rdOp(32'h0003_0000, 32'h1, 32'h0);
		repeat (210) @(posedge clk);
		rdOp(32'h0003_0000, 32'h1, 32'h1);
		wr(REG_CTRL, 32'h2);
		results();
	end
endmodule // tb_plc_scan_operand_memory
